//--- tdi_readout_pkg.sv
// constants shared by the line integration readout configuration block
package tdi_readout_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] ROI_OFFSET_ADDR = 8'h04;
  localparam logic [7:0] ROI_WIDTH_ADDR = 8'h08;
  localparam logic [7:0] LINE_PERIOD_ADDR = 8'h0C;
  localparam logic [7:0] EXPOSURE_ADDR = 8'h10;
  localparam logic [7:0] STATUS_ADDR = 8'h14;
  localparam logic [7:0] EFF_PERIOD_ADDR = 8'h18;
  localparam logic [7:0] LINE_COUNT_ADDR = 8'h1C;
  // control register field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_STAGE_LSB = 1;
  localparam int CTRL_DIR_LSB = 4;
  localparam int CTRL_TAP_LSB = 6;
  // operation mode codes
  localparam logic MODE_LINE_INT = 1'b0;
  localparam logic MODE_AREA = 1'b1;
  // scan direction selector codes
  localparam logic [1:0] DIR_FORWARD = 2'h0;
  localparam logic [1:0] DIR_REVERSE = 2'h1;
  localparam logic [1:0] DIR_EXTERNAL = 2'h2;
  // tap configuration codes
  localparam logic [1:0] TAP_2 = 2'h0;
  localparam logic [1:0] TAP_4 = 2'h1;
  localparam logic [1:0] TAP_8 = 2'h2;
  localparam logic [1:0] TAP_10 = 2'h3;
  // legal stage selector range
  localparam logic [2:0] STAGE_CODE_MIN = 3'h1;
  localparam logic [2:0] STAGE_CODE_MAX = 3'h4;
  localparam logic [2:0] STAGE_CODE_RST = 3'h4;
  // region window granularity and least width
  localparam int ROI_STEP_LOG2 = 4;
  localparam logic [14:0] ROI_MIN_WIDTH = 15'h0100;
  // clock rates and the line rate ceiling
  localparam int PCLK_PERIOD_PS = 4000;
  localparam int LINK_PERIOD_PS = 15000;
  localparam int MAX_LINE_RATE_HZ = 125000;
  // least line period in pclk cycles, rounded up: 1e6 over (rate in khz times clock in ns)
  localparam int MIN_PERIOD_INT =
    (1000000 + (MAX_LINE_RATE_HZ / 1000) * (PCLK_PERIOD_PS / 1000) - 1) /
    ((MAX_LINE_RATE_HZ / 1000) * (PCLK_PERIOD_PS / 1000));
  localparam logic [19:0] MIN_PERIOD_CYC = 20'(MIN_PERIOD_INT);
endpackage

//--- tdi_line_readout_config.sv
// line integration sensor readout configuration with apb registers and link side
`timescale 1ns/10ps

// Function
// [R1] more taps give shorter line transfer time
// [R2] long exposure lengthens the least line period
// [R3] four, eight, ten taps drive both connectors
// [R4] mode code 0 line integration, 1 area
// [R5] line integration uses configured stage count
// [R6] area mode reads stage count rows
// [R7] stage code 1..4 times base step
// [R8] direction code 0 forward, 1 reverse, 2 external
// [R9] external pin low forward, high reverse
// [R10] shift charge bottom to top when forward
// [R11] reverse area images come out row flipped
// [R12] only window pixels offset+1..offset+width sent
// [R13] offset plus width within sensor width
// [R14] offset and width multiples of 16, width >=256
// [R15] reset window is full width at zero
// [R16] eight taps faster for narrower windows, capped
// [R17] no taps reach the top rate at full width; any taps reach it in narrow windows, ten at full width need 4680 cycles
// [R18] requested rate above limit runs at limit
// [R19] settings change only at a line boundary
module tdi_line_readout_config
  import tdi_readout_pkg::*;
#(
  parameter int SENSOR_WIDTH = 12480,
  parameter int STAGE_BASE = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dir_pin,
  output logic [8:0] stage_count,
  output logic shift_reverse,
  output logic area_mode,
  output logic line_start,
  output logic conn2_en,
  input wire logic link_clk,
  output logic link_lval,
  output logic link_fval,
  output logic [14:0] link_pix_addr,
  output logic [3:0] link_pix_count,
  output logic [8:0] link_row
);
  localparam logic [14:0] FULL_WIDTH = 15'(SENSOR_WIDTH);
  // number of pixels moved per link cycle for a tap code
  function automatic logic [3:0] tap_count(input logic [1:0] code);
    unique case (code)
      TAP_2: tap_count = 4'h2;
      TAP_4: tap_count = 4'h4;
      TAP_8: tap_count = 4'h8;
      default: tap_count = 4'hA;
    endcase
  endfunction
  // pclk cycles to move one group of sixteen pixels, rounded up
  function automatic logic [5:0] group_cost(input logic [1:0] code);
    int c;
    c = ((1 << ROI_STEP_LOG2) * LINK_PERIOD_PS + int'(tap_count(code)) * PCLK_PERIOD_PS - 1)
        / (int'(tap_count(code)) * PCLK_PERIOD_PS);
    group_cost = 6'(c);
  endfunction
  // software settings
  logic mode_q; // operation mode
  logic [2:0] stage_code_q; // stage selector
  logic [1:0] dir_sel_q; // direction selector
  logic [1:0] tap_code_q; // output tap configuration
  logic [14:0] roi_off_q; // window offset
  logic [14:0] roi_wid_q; // window width
  logic [19:0] req_period_q; // requested line period in cycles
  logic [19:0] expo_q; // exposure in cycles
  // apb answer
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic hit_d;
  logic wr_en;
  // direction pin synchroniser
  logic dir_meta_q;
  logic dir_sync_q;
  // line timing
  logic [19:0] xfer_cyc; // transfer time of one line
  logic [19:0] eff_d;
  logic [19:0] eff_period_q;
  logic [19:0] cnt_q;
  logic [31:0] lines_q;
  logic line_go;
  logic limited_q;
  logic roi_bad;
  // settings in force for the current line
  logic [8:0] stage_count_q;
  logic shift_reverse_q;
  logic area_mode_q;
  logic line_start_q;
  logic conn2_en_q;
  logic [8:0] row_q; // area row counter
  // bundle held for the link side
  logic [14:0] x_off_q;
  logic [14:0] x_wid_q;
  logic [1:0] x_tap_q;
  logic [8:0] x_row_q;
  logic x_first_q;
  logic x_last_q;
  logic x_tog_q;
  logic next_rev;
  logic [8:0] next_stages;
  assign wr_en = psel & penable & pready_q & pwrite;
  // one wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit_d;
      prdata_q <= (psel & penable & ~pready_q & ~pwrite) ? rd_d : 32'h0000_0000;
    end
  end
  // read decode, unmapped addresses read zero and flag an error
  always_comb begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    unique case (paddr)
      CTRL_ADDR: begin
        rd_d[CTRL_MODE_BIT] = mode_q;
        rd_d[CTRL_STAGE_LSB +: 3] = stage_code_q;
        rd_d[CTRL_DIR_LSB +: 2] = dir_sel_q;
        rd_d[CTRL_TAP_LSB +: 2] = tap_code_q;
      end
      ROI_OFFSET_ADDR: rd_d[14:0] = roi_off_q;
      ROI_WIDTH_ADDR: rd_d[14:0] = roi_wid_q;
      LINE_PERIOD_ADDR: rd_d[19:0] = req_period_q;
      EXPOSURE_ADDR: rd_d[19:0] = expo_q;
      STATUS_ADDR: rd_d[3:0] = {roi_bad, limited_q, area_mode_q, shift_reverse_q};
      EFF_PERIOD_ADDR: rd_d[19:0] = eff_period_q;
      LINE_COUNT_ADDR: rd_d = lines_q;
      default: hit_d = 1'b0;
    endcase
  end
  // control register write; illegal codes leave a field unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_LINE_INT;
      stage_code_q <= STAGE_CODE_RST;
      dir_sel_q <= DIR_FORWARD;
      tap_code_q <= TAP_10;
    end else if (wr_en && paddr == CTRL_ADDR) begin
      mode_q <= pwdata[CTRL_MODE_BIT]; // R4
      if (pwdata[CTRL_STAGE_LSB +: 3] >= STAGE_CODE_MIN &&
          pwdata[CTRL_STAGE_LSB +: 3] <= STAGE_CODE_MAX) begin
        stage_code_q <= pwdata[CTRL_STAGE_LSB +: 3]; // R7
      end
      if (pwdata[CTRL_DIR_LSB +: 2] != 2'h3) begin
        dir_sel_q <= pwdata[CTRL_DIR_LSB +: 2]; // R8
      end
      tap_code_q <= pwdata[CTRL_TAP_LSB +: 2];
    end
  end
  // window registers come up covering the whole sensor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      roi_off_q <= 15'h0000; // R15
      roi_wid_q <= FULL_WIDTH; // R15
    end else if (wr_en) begin
      if (paddr == ROI_OFFSET_ADDR) begin
        roi_off_q <= pwdata[14:0];
      end
      if (paddr == ROI_WIDTH_ADDR) begin
        roi_wid_q <= pwdata[14:0];
      end
    end
  end
  // line period request and exposure time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_period_q <= MIN_PERIOD_CYC;
      expo_q <= 20'h00000;
    end else if (wr_en) begin
      if (paddr == LINE_PERIOD_ADDR) begin
        req_period_q <= pwdata[19:0];
      end
      if (paddr == EXPOSURE_ADDR) begin
        expo_q <= pwdata[19:0];
      end
    end
  end
  // window check only reported; the configuring side keeps it legal
  assign roi_bad = (16'(roi_off_q) + 16'(roi_wid_q) > 16'(FULL_WIDTH)) || // R13
                   (roi_off_q[ROI_STEP_LOG2-1:0] != '0) || // R14
                   (roi_wid_q[ROI_STEP_LOG2-1:0] != '0) || // R14
                   (roi_wid_q < ROI_MIN_WIDTH); // R14
  // direction pin passes two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_meta_q <= 1'b0;
      dir_sync_q <= 1'b0;
    end else begin
      dir_meta_q <= dir_pin;
      dir_sync_q <= dir_meta_q;
    end
  end
  // transfer time falls with tap count and rises with window width
  assign xfer_cyc = 20'(roi_wid_q >> ROI_STEP_LOG2) * 20'(group_cost(tap_code_q)); // R1 R16 R17
  // least period is the largest of ceiling, transfer, exposure, request
  always_comb begin
    eff_d = MIN_PERIOD_CYC; // R16
    if (xfer_cyc > eff_d) begin
      eff_d = xfer_cyc; // R17
    end
    if (expo_q > eff_d) begin
      eff_d = expo_q; // R2
    end
    if (req_period_q > eff_d) begin
      eff_d = req_period_q; // R18
    end
  end
  // selected direction and stage count for the next line
  assign next_rev = (dir_sel_q == DIR_EXTERNAL) ? dir_sync_q : // R9
                    (dir_sel_q == DIR_REVERSE); // R8
  assign next_stages = 9'(stage_code_q) * 9'(STAGE_BASE); // R7
  // free running line timer at the effective period
  assign line_go = (cnt_q >= eff_period_q - 20'h00001);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 20'h00000;
      eff_period_q <= MIN_PERIOD_CYC;
      limited_q <= 1'b0;
      lines_q <= 32'h0000_0000;
    end else begin
      eff_period_q <= eff_d;
      limited_q <= (eff_d != req_period_q); // R18
      cnt_q <= line_go ? 20'h00000 : cnt_q + 20'h00001;
      if (line_go) begin
        lines_q <= lines_q + 32'h0000_0001;
      end
    end
  end

  // settings latched only when a line starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_count_q <= 9'(STAGE_CODE_RST) * 9'(STAGE_BASE);
      shift_reverse_q <= 1'b0;
      area_mode_q <= MODE_LINE_INT;
      conn2_en_q <= 1'b1;
      line_start_q <= 1'b0;
    end else begin
      line_start_q <= line_go;
      if (line_go) begin
        stage_count_q <= next_stages; // R5 R6 R19
        shift_reverse_q <= next_rev; // R10 R19
        area_mode_q <= mode_q; // R4 R19
        conn2_en_q <= (tap_code_q != TAP_2); // R3
      end
    end
  end

  // area row counter; rows equal the stage count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_q <= 9'h000;
    end else if (line_go) begin
      if (mode_q != MODE_AREA || row_q >= next_stages - 9'h001) begin
        row_q <= 9'h000; // R6
      end else begin
        row_q <= row_q + 9'h001;
      end
    end
  end

  // bundle for the link, stable for a whole line, then the toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_off_q <= 15'h0000;
      x_wid_q <= FULL_WIDTH;
      x_tap_q <= TAP_10;
      x_row_q <= 9'h000;
      x_first_q <= 1'b0;
      x_last_q <= 1'b0;
      x_tog_q <= 1'b0;
    end else if (line_go) begin
      x_off_q <= roi_off_q; // R12 R19
      x_wid_q <= roi_wid_q; // R12 R19
      x_tap_q <= tap_code_q; // R19
      x_row_q <= (mode_q != MODE_AREA) ? 9'h000 : // R6
                 (next_rev ? next_stages - 9'h001 - row_q : row_q); // R11
      x_first_q <= (mode_q != MODE_AREA) || (row_q == 9'h000);
      x_last_q <= (mode_q != MODE_AREA) || (row_q >= next_stages - 9'h001);
      x_tog_q <= ~x_tog_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stage_count = stage_count_q;
  assign shift_reverse = shift_reverse_q;
  assign area_mode = area_mode_q;
  assign line_start = line_start_q;
  assign conn2_en = conn2_en_q;

  // ---------------- link clock domain ----------------
  logic lrst_meta_q;
  logic lrst_n_q; // reset released in step with link_clk
  logic tog_meta_q;
  logic tog_sync_q;
  logic tog_prev_q;
  logic l_go;
  logic l_lval_q;
  logic l_fval_q;
  logic l_last_q;
  logic [14:0] l_addr_q;
  logic [14:0] l_left_q;
  logic [3:0] l_taps_q;
  logic [3:0] l_cnt_q;
  logic [8:0] l_row_q;

  // reset asserts at once and releases on the link clock
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      lrst_meta_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_meta_q <= 1'b1;
      lrst_n_q <= lrst_meta_q;
    end
  end

  // line toggle crossing; the second and third flops feed the edge detect, the first does not
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      tog_meta_q <= 1'b0;
      tog_sync_q <= 1'b0;
      tog_prev_q <= 1'b0;
    end else begin
      tog_meta_q <= x_tog_q;
      tog_sync_q <= tog_meta_q;
      tog_prev_q <= tog_sync_q;
    end
  end
  assign l_go = tog_sync_q ^ tog_prev_q;

  // pixel walk over the window, one tap group per link cycle
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      l_lval_q <= 1'b0;
      l_addr_q <= 15'h0000;
      l_left_q <= 15'h0000;
      l_taps_q <= 4'h0;
      l_cnt_q <= 4'h0;
      l_row_q <= 9'h000;
      l_last_q <= 1'b0;
    end else if (l_go) begin
      l_lval_q <= 1'b1;
      l_addr_q <= x_off_q + 15'h0001; // R12
      l_taps_q <= tap_count(x_tap_q); // R1
      l_left_q <= (x_wid_q > 15'(tap_count(x_tap_q))) ? x_wid_q - 15'(tap_count(x_tap_q)) : '0;
      l_cnt_q <= (x_wid_q > 15'(tap_count(x_tap_q))) ? tap_count(x_tap_q) : 4'(x_wid_q);
      l_row_q <= x_row_q; // R11
      l_last_q <= x_last_q;
    end else if (l_lval_q) begin
      if (l_left_q == 15'h0000) begin
        l_lval_q <= 1'b0; // window done
        l_cnt_q <= 4'h0;
      end else begin
        l_addr_q <= l_addr_q + 15'(l_taps_q);
        l_left_q <= (l_left_q > 15'(l_taps_q)) ? l_left_q - 15'(l_taps_q) : '0;
        l_cnt_q <= (l_left_q > 15'(l_taps_q)) ? l_taps_q : 4'(l_left_q); // R12
      end
    end
  end

  // frame valid spans first to last row of an area image
  always_ff @(posedge link_clk or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      l_fval_q <= 1'b0;
    end else if (l_go && x_first_q) begin
      l_fval_q <= 1'b1; // R6
    end else if (l_lval_q && l_left_q == 15'h0000 && l_last_q) begin
      l_fval_q <= 1'b0;
    end
  end

  assign link_lval = l_lval_q;
  assign link_fval = l_fval_q;
  assign link_pix_addr = l_addr_q;
  assign link_pix_count = l_cnt_q;
  assign link_row = l_row_q;

endmodule

//--- tdi_line_readout_config_asserts.sv
// concurrent checks on the readout configuration block ports
`timescale 1ns/10ps
module tdi_readout_checker
  import tdi_readout_pkg::*;
#(
  parameter int STAGE_BASE = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [8:0] stage_count,
  input wire logic shift_reverse,
  input wire logic area_mode,
  input wire logic line_start
);
  logic [19:0] gap_q; // cycles since the last line start
  logic seen_q; // a line start has been seen since reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb setup and access steps
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  // measure the line spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 20'h0;
      seen_q <= 1'b0;
    end else if (line_start) begin
      gap_q <= 20'h0;
      seen_q <= 1'b1;
    end else begin
      gap_q <= gap_q + 20'h1;
    end
  end
  chk_apb_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not on second access cycle");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_needs_req: assert property (pready |-> psel && penable)
    else $error("pready without request");
  chk_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero while idle");
  chk_err_unmapped: assert property (pready && paddr > LINE_COUNT_ADDR |-> pslverr)
    else $error("no pslverr on unmapped address");
  chk_err_mapped: assert property (pready && paddr <= LINE_COUNT_ADDR && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("pslverr on mapped address");
  chk_start_pulse: assert property (line_start |=> !line_start)
    else $error("line start longer than one cycle");
  chk_stage_legal: assert property (stage_count != 9'h0 &&
    int'(stage_count) % STAGE_BASE == 0 && int'(stage_count) <= 4 * STAGE_BASE)
    else $error("stage count not a legal multiple");
  chk_apply_boundary: assert property (
    !$stable({stage_count, shift_reverse, area_mode}) |-> line_start)
    else $error("settings changed away from a line boundary");
  chk_line_gap_min: assert property (line_start && seen_q |-> gap_q >= MIN_PERIOD_CYC - 20'h00001)
    else $error("line rate above ceiling");
endmodule

bind tdi_line_readout_config tdi_readout_checker #(.STAGE_BASE(STAGE_BASE)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .stage_count(stage_count),
  .shift_reverse(shift_reverse), .area_mode(area_mode), .line_start(line_start)
);

//--- frame_grabber_model.sv
// receiving side of the video link: gathers one report per line
`timescale 1ns/10ps
module frame_grabber_model (
  input wire logic link_clk,
  input wire logic conn2_en,
  input wire logic link_lval,
  input wire logic [14:0] link_pix_addr,
  input wire logic [3:0] link_pix_count,
  output logic rep_stb,
  output logic [32:0] rep_word
);
  logic in_line_q = 1'b0; // inside a line
  logic [14:0] first_q = 15'h0; // first pixel number of the line
  logic [17:0] total_q = 18'h0; // pixels taken so far
  initial rep_stb = 1'b0;
  initial rep_word = 33'h0;
  // both cables attached whenever the second connector is driven
  wire both_cables = conn2_en;
  // take every valid group, report at the end of the line
  always @(posedge link_clk) begin
    rep_stb <= 1'b0;
    if (link_lval === 1'b1) begin
      if (!in_line_q) begin
        first_q <= link_pix_addr;
      end
      total_q <= (in_line_q ? total_q : 18'h0) + 18'(link_pix_count);
      in_line_q <= 1'b1;
    end else if (in_line_q) begin
      rep_stb <= 1'b1;
      rep_word <= {first_q, total_q};
      in_line_q <= 1'b0;
    end
  end
endmodule

//--- test_tdi_line_readout_config.sv
// self-checking bench for the readout configuration block
`timescale 1ns/10ps
module test_tdi_line_readout_config;
  import tdi_readout_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dir_pin = 0, link_clk = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, shift_reverse, area_mode, line_start, conn2_en;
  logic link_lval, link_fval, rep_stb;
  logic [8:0] stage_count, link_row;
  logic [14:0] link_pix_addr;
  logic [3:0] link_pix_count;
  logic [32:0] rep_word;
  logic [32:0] rd_q[$], ln_q[$]; // expected reads and lines
  int n_errors = 0, tests_run = 0;
  logic [15:0] lfsr_q = 16'hEBAA; // random state
  always #2 pclk = ~pclk;
  always #7.5 link_clk = ~link_clk;
  tdi_line_readout_config uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dir_pin(dir_pin), .stage_count(stage_count),
    .shift_reverse(shift_reverse), .area_mode(area_mode), .line_start(line_start),
    .conn2_en(conn2_en), .link_clk(link_clk), .link_lval(link_lval), .link_fval(link_fval),
    .link_pix_addr(link_pix_addr), .link_pix_count(link_pix_count), .link_row(link_row));
  frame_grabber_model partner (.link_clk(link_clk), .conn2_en(conn2_en),
    .link_lval(link_lval), .link_pix_addr(link_pix_addr), .link_pix_count(link_pix_count),
    .rep_stb(rep_stb), .rep_word(rep_word));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctrl(input logic m, input int st, input int d, input int t);
    return {24'h0, 2'(t), 2'(d), 3'(st), m};
  endfunction
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [32:0] e, input logic [32:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin n_errors++; close_out(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
    rd_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // wait for n line starts, bounded
  task automatic wait_lines(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin @(posedge pclk); i++; end while (line_start !== 1'b1 && i < 30000);
      if (i >= 30000) begin n_errors++; close_out(); end
    end
  endtask
  // compare read data as it is returned
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) begin
      check("prdata", rd_q.pop_front(), {pslverr, prdata});
    end
  end
  // compare each reported link line with its note
  always @(posedge link_clk) begin
    if (rep_stb === 1'b1 && ln_q.size() > 0) begin
      check("line", ln_q.pop_front(), rep_word);
    end
  end
  initial begin
    int cost[4] = '{30, 15, 8, 6};
    int dirs[4] = '{0, 1, 2, 2};
    logic pins[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic [14:0] off, w;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("stage", 33'd256, 33'(stage_count));
    check("conn2", 33'd1, 33'(conn2_en));
    rd(CTRL_ADDR, 32'hC8);
    rd(ROI_OFFSET_ADDR, 32'h0);
    rd(ROI_WIDTH_ADDR, 32'd12480);
    wr(EFF_PERIOD_ADDR, 32'h0);
    rd(EFF_PERIOD_ADDR, 32'd4680);
    rd(8'h20, 32'h0, 1'b1);
    for (int t = 0; t < 4; t++) begin
      wr(CTRL_ADDR, ctrl(1'b0, 4, 0, t));
      rd(EFF_PERIOD_ADDR, 32'(780 * cost[t]));
    end
    wr(ROI_WIDTH_ADDR, 32'd4096);
    wr(CTRL_ADDR, ctrl(1'b0, 4, 0, 2));
    rd(EFF_PERIOD_ADDR, 32'd2048);
    wr(ROI_WIDTH_ADDR, 32'd256);
    rd(EFF_PERIOD_ADDR, 32'd2000);
    wr(CTRL_ADDR, ctrl(1'b0, 4, 0, 0));
    wait_lines(2);
    check("conn2", 33'd0, 33'(conn2_en));
    wr(CTRL_ADDR, ctrl(1'b0, 4, 0, 3));
    wr(EXPOSURE_ADDR, 32'd3000);
    rd(EFF_PERIOD_ADDR, 32'd3000);
    wr(EXPOSURE_ADDR, 32'd0);
    wr(LINE_PERIOD_ADDR, 32'd1000);
    rd(EFF_PERIOD_ADDR, 32'd2000);
    rd(STATUS_ADDR, 32'h4);
    wr(LINE_PERIOD_ADDR, 32'd2500);
    rd(EFF_PERIOD_ADDR, 32'd2500);
    wr(LINE_PERIOD_ADDR, 32'd2000);
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      off = {5'h0, lfsr_q[5:0], 4'h0};
      w = 15'd256 + {7'h0, lfsr_q[9:6], 4'h0};
      wr(ROI_OFFSET_ADDR, 32'(off));
      wr(ROI_WIDTH_ADDR, 32'(w));
      dir_pin <= pins[i];
      wr(CTRL_ADDR, ctrl(i[0], i + 1, dirs[i], 3));
      wait_lines(2);
      check("mode", {22'h0, i[0], dirs[i] == 1 || (dirs[i] == 2 && pins[i]), 9'(64 * (i + 1))},
        {22'h0, area_mode, shift_reverse, stage_count});
      check("link", {23'h0, i[0], 9'((i[0] && dirs[i] == 1) ? 64 * (i + 1) - 1 : 0)},
        {23'h0, link_fval, link_row});
      ln_q.push_back({15'(off + 15'd1), 18'(w)});
    end
    dir_pin <= 1'b1;
    wr(CTRL_ADDR, ctrl(1'b0, 7, 3, 3));
    wait_lines(2);
    check("refused", 33'h3_00, {22'h0, area_mode, shift_reverse, stage_count});
    wait_lines(1);
    check("pending", 33'd0, 33'(ln_q.size()));
    close_out();
  end
endmodule
